//--- rtl/csw_pkg.sv
// Package for the channel switch target: address, widths and states.
package csw_pkg;
  localparam logic [6:0] CSW_ADDR_BASE = 7'h70;
  localparam int CSW_CH_W = 8;
  localparam int CSW_BIT_LAST = 7;
  localparam int CSW_SEL_LOW_W = 3;
  localparam logic [7:0] CSW_SEL_RST = 8'h00;
  localparam logic [3:0] CSW_BITCNT_RST = 4'h0;
  localparam logic [3:0] CSW_BITCNT_ACK = 4'h8;
  localparam logic [3:0] CSW_BITCNT_ONE = 4'h1;
  localparam logic [1:0] CSW_SYNC_RST = 2'h0;
  typedef enum logic [2:0] {
    CSW_IDLE = 3'b000,
    CSW_ADDR = 3'b001,
    CSW_AACK = 3'b010,
    CSW_WDAT = 3'b011,
    CSW_WACK = 3'b100,
    CSW_RDAT = 3'b101,
    CSW_RACK = 3'b110
  } csw_state_type;
endpackage

//--- rtl/csw_rst_sync.sv
// Reset combiner: asynchronous assertion, synchronous release.
`timescale 1ns/1ps
module csw_rst_sync (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Hardware reset input, active low.
  input wire logic por_n, // Power-on reset from core supply monitor.
  output logic rst_out_n // Combined reset for the core logic.
);
  import csw_pkg::*;
  logic any_rst_n;
  logic [1:0] sync_r;
  assign any_rst_n = rst_n & por_n;
  // Release is held until two edges after both sources go high.
  always_ff @(posedge sys_clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      sync_r <= CSW_SYNC_RST;
    end else begin
      sync_r <= {sync_r[0], 1'b1};
    end
  end
  assign rst_out_n = sync_r[1];
endmodule

//--- rtl/csw_switch_ctl.sv
// I2C target logic of the eight-channel bus switch.
// Contract
// - Reset input low clears selection, idles bus machine, deselects all.
// - Power-on reset holds logic until core supply passes threshold.
// - After power-on release, registers and state start at zero; the bus line history starts at one.
// - Target address with write direction is acknowledged.
// - Upper bits 7 to 3 of a written byte are disregarded.
// - Any number of data bytes is accepted in one write.
// - Only the last byte before stop becomes the selection.
// - New selection connects channels only after the stop.
// - Target address with read direction is acknowledged, then byte sent.
// - Selection byte is resent while the controller acknowledges.
// - Read value reflects channels set by last completed write.
// - Each selection bit enables one channel.
`timescale 1ns/1ps
module csw_switch_ctl
  import csw_pkg::*;
#(
  parameter int CH_W = CSW_CH_W,
  parameter bit USE_LOW_BITS = 1'b1
) (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rst_n, // Hardware reset, active low.
  input wire logic por_n, // Power-on reset, low until core_supply is good.
  input wire logic [1:0] addr_pins, // Address select straps.
  input wire logic scl_in, // Bus clock level.
  input wire logic sda_in, // Bus data level.
  output logic sda_out, // Bus data drive value, always low.
  output logic sda_oe, // Bus data driven low when high.
  output logic [CH_W-1:0] chan_en // Downstream channel enables.
);
  // The byte-wide selection logic serves exactly eight channels.
  if (CH_W != CSW_CH_W) begin : g_bad_width
    $error("csw_switch_ctl: CH_W must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both reset sources meet here; the core sees one clean release.
  logic core_rst_n;
  csw_rst_sync u_rst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .por_n(por_n),
    .rst_out_n(core_rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus line history; inputs are already synchronous.
  logic scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  always_ff @(posedge sys_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
    end
  end
  assign scl_rise = scl_in & ~scl_d_r;
  assign scl_fall = ~scl_in & scl_d_r;
  assign start_det = scl_in & scl_d_r & sda_d_r & ~sda_in;
  assign stop_det = scl_in & scl_d_r & ~sda_d_r & sda_in;

  // Written byte as held by the selection register.
  function automatic logic [7:0] sel_mask(input logic [7:0] b);
    sel_mask = USE_LOW_BITS ? {5'h00, b[CSW_SEL_LOW_W-1:0]} : b;
  endfunction

  // Address byte matches the fixed upper bits and the two strap pins.
  function automatic logic addr_hit(input logic [7:0] b, input logic [1:0] p);
    addr_hit = (b[7:1] == {CSW_ADDR_BASE[6:2], p});
  endfunction

  // Bit counter step, shared by the receive and send paths.
  function automatic logic [3:0] cnt_step(input logic [3:0] c);
    cnt_step = c + CSW_BITCNT_ONE;
  endfunction

  // A zero data bit pulls the line low; a one leaves it to the pull-up.
  function automatic logic rd_oe(input logic [7:0] b, input logic [2:0] i);
    rd_oe = ~b[CSW_BIT_LAST - i];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bytes wait in the pending register until a stop commits them.
  csw_state_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic pend_v_r, pend_v_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic rw_r, rw_nxt;
  logic oe_r, oe_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    sel_nxt = sel_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    if (stop_det) begin
      // Channels change only here, when all lines are high.
      if (pend_v_r) begin
        sel_nxt = pend_r;
      end
      pend_v_nxt = 1'b0;
      state_nxt = CSW_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      // A repeated start drops any byte not yet committed by a stop.
      pend_v_nxt = 1'b0;
      state_nxt = CSW_ADDR;
      cnt_nxt = CSW_BITCNT_RST;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        CSW_IDLE: begin
          oe_nxt = 1'b0;
        end
        CSW_ADDR, CSW_WDAT: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_step(cnt_r);
          end else if (scl_fall && cnt_r == CSW_BITCNT_ACK) begin
            cnt_nxt = CSW_BITCNT_RST;
            if (state_r == CSW_ADDR) begin
              if (addr_hit(sh_r, addr_pins)) begin
                rw_nxt = sh_r[0];
                oe_nxt = 1'b1;
                state_nxt = CSW_AACK;
              end else begin
                // A foreign address leaves the line alone until a start.
                state_nxt = CSW_IDLE;
              end
            end else begin
              pend_nxt = sel_mask(sh_r);
              pend_v_nxt = 1'b1;
              oe_nxt = 1'b1;
              state_nxt = CSW_WACK;
            end
          end
        end
        CSW_AACK, CSW_WACK: begin
          // The ninth clock ends here; reads preload the register byte.
          if (scl_fall) begin
            if (rw_r) begin
              sh_nxt = sel_r;
              oe_nxt = rd_oe(sel_r, CSW_BITCNT_RST[2:0]);
              cnt_nxt = CSW_BITCNT_ONE;
              state_nxt = CSW_RDAT;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = CSW_WDAT;
            end
          end
        end
        CSW_RDAT: begin
          // Each falling clock moves the next bit out, MSB first.
          if (scl_fall) begin
            if (cnt_r == CSW_BITCNT_ACK) begin
              oe_nxt = 1'b0;
              state_nxt = CSW_RACK;
            end else begin
              oe_nxt = rd_oe(sh_r, cnt_r[2:0]);
              cnt_nxt = cnt_step(cnt_r);
            end
          end
        end
        CSW_RACK: begin
          // The controller's answer is sampled on the rising clock; a
          // not-acknowledge leaves the line released and waits for the stop.
          if (scl_rise) begin
            if (sda_in) begin
              state_nxt = CSW_IDLE;
            end else begin
              state_nxt = CSW_AACK;
            end
          end
        end
        default: begin
          state_nxt = CSW_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // Asynchronous clear so a stuck bus is freed with the bus clock
  // stopped; the synchroniser above keeps the release clean.
  always_ff @(posedge sys_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state_r <= CSW_IDLE;
      cnt_r <= CSW_BITCNT_RST;
      sh_r <= CSW_SEL_RST;
      pend_r <= CSW_SEL_RST;
      pend_v_r <= 1'b0;
      sel_r <= CSW_SEL_RST;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      sel_r <= sel_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open drain: the value is fixed low and only the enable moves.
  assign sda_oe = oe_r;
  assign sda_out = 1'b0;
  assign chan_en = sel_r;
endmodule

//--- bench/csw_chk_properties.sv
// Port checker for the channel switch target.
`timescale 1ns/1ps
module csw_chk
  import csw_pkg::*;
#(
  parameter int CH_W = CSW_CH_W,
  parameter bit USE_LOW_BITS = 1'b1
) (
  input wire logic sys_clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic por_n, // Power-on reset, active low.
  input wire logic scl_in, // Bus clock.
  input wire logic sda_in, // Bus data.
  input wire logic sda_out, // Data drive value.
  input wire logic sda_oe, // Data drive enable.
  input wire logic [CH_W-1:0] chan_en // Channel enables.
);
  logic scl_r, sda_r, stp;
  logic [3:0] stp_r;
  assign stp = scl_in & scl_r & sda_in & ~sda_r;
  always_ff @(posedge sys_clk) begin
    scl_r <= scl_in;
    sda_r <= sda_in;
    stp_r <= {stp_r[2:0], stp};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!(rst_n && por_n));
  sequence quiet3;
    (chan_en == '0 && !sda_oe) [*3];
  endsequence
  chk_chan_at_stop:
    assert property ($changed(chan_en) |-> |stp_r) else $error("early");
  chk_upper_zero:
    assert property (USE_LOW_BITS |-> chan_en[CH_W-1:CSW_SEL_LOW_W] == '0)
      else $error("upper bits");
  chk_rst_clear:
    assert property (disable iff (1'b0) !rst_n |-> chan_en == '0 && !sda_oe)
      else $error("reset");
  chk_por_clear:
    assert property (disable iff (1'b0) !por_n |-> chan_en == '0 && !sda_oe)
      else $error("power-on");
  chk_release_quiet:
    assert property (disable iff (1'b0) $rose(rst_n && por_n) |-> quiet3)
      else $error("release");
  chk_oe_scl_low:
    assert property ($changed(sda_oe) |-> !scl_in) else $error("oe");
  chk_free_at_start:
    assert property (scl_in && scl_r && !sda_in && sda_r |-> !sda_oe)
      else $error("start");
  chk_drive_low:
    assert property (sda_out == 1'b0) else $error("drive");
endmodule

//--- bench/csw_host_model.sv
// Upstream bus controller model on an open-drain data line.
`timescale 1ns/1ps
module csw_host_model (
  input wire logic sys_clk, // System clock.
  input wire logic sda_oe, // Target pulls data low.
  output logic scl, // Bus clock line.
  output logic sda // Resolved data line.
);
  logic drv = 1'b1;
  initial scl = 1'b1;
  // The pull-up wins whenever nobody drives the line low.
  assign sda = drv & ~sda_oe;
  task automatic hp(); repeat (4) @(negedge sys_clk); endtask
  // Start when first is high, stop when low.
  task automatic cond(input logic first);
    drv = first;
    hp();
    scl = 1'b1;
    hp();
    drv = ~first;
    hp();
    scl = ~first;
  endtask
  // Nine bits, MSB first; a one lets the target answer.
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      drv = d[i];
      hp();
      scl = 1'b1;
      hp();
      q[i] = sda;
      scl = 1'b0;
      hp();
    end
  endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the channel switch target.
`timescale 1ns/1ps
module tb_top;
  import csw_pkg::*;
  localparam logic [6:0] ADR = {CSW_ADDR_BASE[6:2], 2'b10};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic scl, sda, sda_out, sda_oe;
  logic [7:0] chan_en;
  logic [8:0] q;
  localparam logic [6:0] ADR8 = {CSW_ADDR_BASE[6:2], 2'b01};
  logic [1:0] addr_sel = 2'b10;
  logic [1:0] addr_sel8 = 2'b01;
  logic sda_out8, sda_oe8;
  logic [7:0] chan_en8;
  int bad_count = 0;
  int samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  csw_switch_ctl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n),
    .addr_pins(addr_sel), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .chan_en(chan_en));
  // Second target keeps all eight selection bits.
  csw_switch_ctl #(.USE_LOW_BITS(1'b0)) i_dut8 (.sys_clk(sys_clk),
    .rst_n(rst_n), .por_n(por_n), .addr_pins(addr_sel8), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out8), .sda_oe(sda_oe8), .chan_en(chan_en8));
  csw_host_model i_h (.sys_clk(sys_clk), .sda_oe(sda_oe | sda_oe8),
    .scl(scl), .sda(sda));
  task automatic check(string what, logic [8:0] got, logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wr_multi();
    i_h.cond(1'b1);
    i_h.xfer({ADR, 2'b01}, q);
    check("wr addr", q, {ADR, 2'b00});
    i_h.xfer(9'h1ff, q);
    i_h.xfer(9'h1fb, q);
    check("wr data", q, 9'h1fa);
    check("before stop", {1'b0, chan_en}, 9'h000);
    i_h.cond(1'b0);
    check("after stop", {1'b0, chan_en}, 9'h005);
  endtask
  task automatic rd_repeat();
    i_h.cond(1'b1);
    i_h.xfer({ADR, 2'b11}, q);
    check("rd addr", q, {ADR, 2'b10});
    i_h.xfer(9'h1fe, q);
    check("rd acked", q, 9'h00a);
    i_h.xfer(9'h1ff, q);
    check("rd nacked", q, 9'h00b);
    i_h.cond(1'b0);
  endtask
  task automatic foreign();
    i_h.cond(1'b1);
    i_h.xfer({ADR ^ 7'h01, 2'b01}, q);
    check("foreign", q, {ADR ^ 7'h01, 2'b01});
    i_h.xfer(9'h00f, q);
    i_h.cond(1'b0);
    check("kept", {1'b0, chan_en}, 9'h005);
    addr_sel = 2'b11;
    i_h.cond(1'b1);
    i_h.xfer({ADR ^ 7'h01, 2'b01}, q);
    check("strap moved", q, {ADR ^ 7'h01, 2'b00});
    i_h.cond(1'b0);
    addr_sel = 2'b10;
    check("empty write", {1'b0, chan_en}, 9'h005);
  endtask
  task automatic wr_full();
    i_h.cond(1'b1);
    i_h.xfer({ADR8, 2'b01}, q);
    check("wr8 addr", q, {ADR8, 2'b00});
    i_h.xfer(9'h1fb, q);
    check("wr8 data", q, 9'h1fa);
    i_h.cond(1'b0);
    check("all bits", {1'b0, chan_en8}, 9'h0fd);
    check("other kept", {1'b0, chan_en}, 9'h005);
    i_h.cond(1'b1);
    i_h.xfer({ADR8, 2'b11}, q);
    check("rd8 addr", q, {ADR8, 2'b10});
    i_h.xfer(9'h1ff, q);
    check("rd8 data", q, 9'h1fb);
    i_h.cond(1'b0);
  endtask
  task automatic resets();
    rst_n = 1'b0;
    #1;
    check("rst", {1'b0, chan_en}, 9'h000);
    check("rst full", {1'b0, chan_en8}, 9'h000);
    @(negedge sys_clk);
    rst_n = 1'b1;
    wr_multi();
    por_n = 1'b0;
    #1;
    check("por", {1'b0, chan_en}, 9'h000);
    @(negedge sys_clk);
    por_n = 1'b1;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("power-up", {1'b0, chan_en}, 9'h000);
    wr_multi();
    rd_repeat();
    foreign();
    wr_full();
    resets();
    repeat (8) @(negedge sys_clk);
    print_verdict();
  end
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
bind csw_switch_ctl csw_chk #(.CH_W(CH_W), .USE_LOW_BITS(USE_LOW_BITS))
  i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chan_en(chan_en));
